// file: src/haf_pkg.sv
package haf_pkg;

	// Byte register map of the audio fetch engine.
	localparam logic [31:0] OFS_BURST_CFG  = 32'h0012_3600;
	localparam logic [31:0] OFS_START      = 32'h0012_3601;
	localparam logic [31:0] OFS_STOP       = 32'h0012_3602;
	localparam logic [31:0] OFS_THRESHOLD  = 32'h0012_3603;
	localparam logic [31:0] OFS_IRQ_STAT   = 32'h0012_3604;
	localparam logic [31:0] OFS_CHAN_ALLOC = 32'h0012_3605;
	localparam logic [31:0] OFS_BEGIN_ADDR = 32'h0012_3608;
	localparam logic [31:0] OFS_END_ADDR   = 32'h0012_360c;

	// Field positions.
	localparam int BIT_CFG_SEL_LO   = 1;
	localparam int BIT_START_READY  = 0;
	localparam int BIT_STOP_REQ     = 0;
	localparam int BIT_STAT_ERR     = 1;
	localparam int BIT_STAT_DONE    = 2;

	// Values after reset.
	localparam logic [7:0] RST_BURST_CFG  = 8'h00;
	localparam logic [7:0] RST_THRESHOLD  = 8'h00;
	localparam logic [7:0] RST_CHAN_ALLOC = 8'hff;

	// Bus transfer encodings.
	localparam logic [1:0] TRANS_IDLE   = 2'h0;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic [1:0] TRANS_SEQ    = 2'h3;
	localparam logic [2:0] BURST_INCR   = 3'h1;
	localparam logic [2:0] BURST_INCR4  = 3'h3;
	localparam logic [2:0] BURST_INCR8  = 3'h5;
	localparam logic [2:0] BURST_INCR16 = 3'h7;
	localparam logic [2:0] SIZE_WORD    = 3'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;

	// Burst type selection in the burst configuration register.
	typedef enum logic [1:0] {
		HAF_SEL_INCR   = 2'h0,
		HAF_SEL_INCR4  = 2'h1,
		HAF_SEL_INCR8  = 2'h2,
		HAF_SEL_INCR16 = 2'h3
	} haf_burst_sel_t;

	// Engine states.
	typedef enum logic [2:0] {
		HAF_IDLE  = 3'h1,
		HAF_RUN   = 3'h2,
		HAF_DRAIN = 3'h4
	} haf_state_t;

	// Master address and control phase.
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic [2:0]  hburst;
		logic [2:0]  hsize;
		logic        hwrite;
	} haf_ahb_req_t;

	// Slave answer seen by the master.
	typedef struct packed {
		logic [31:0] hrdata;
		logic        hready;
		logic [1:0]  hresp;
	} haf_ahb_rsp_t;

endpackage

// file: src/haf_audio_fetch.sv
module haf_audio_fetch #(
	parameter int DEPTH = 128
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [31:0]           reg_addr_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	input  wire logic [7:0]            reg_wdata_i,
	output logic      [7:0]            reg_rdata_o,
	output haf_pkg::haf_ahb_req_t      ahb_req_o,
	input  wire haf_pkg::haf_ahb_rsp_t ahb_rsp_i,
	output logic                       sample_valid_o,
	input  wire logic                  sample_ready_i,
	output logic      [31:0]           sample_data_o,
	output logic      [7:0]            chan_enable_o,
	output logic                       irq_done_o
);

	localparam int CW = $clog2(DEPTH) + 1;

	logic [7:0]          burst_cfg_q;
	logic [7:0]          threshold_q;
	logic [7:0]          chan_alloc_q;
	logic [31:0]         begin_addr_q;
	logic [31:0]         end_addr_q;
	logic                stop_req_q;
	logic                done_q;
	logic                err_q;
	logic [7:0]          rdata_q;
	haf_pkg::haf_state_t state_q;
	logic [31:0]         addr_q;
	logic [4:0]          beats_left_q;
	logic                dphase_q;
	logic                full_hold_q;
	logic                nonseq_wait_q;
	logic [31:0]         mem_q [DEPTH];
	logic [CW-2:0]       wptr_q;
	logic [CW-2:0]       rptr_q;
	logic [CW-1:0]       count_q;

	logic                wr_hit;
	logic                start_wr;
	logic                stop_wr;
	logic [4:0]          burst_len;
	logic [2:0]          burst_code;
	logic                fixed_ok;
	logic                can_start;
	logic                last_addr;
	logic                addr_take;
	logic                data_take;
	logic                push;
	logic                pop;
	logic                done_evt;
	logic [CW-1:0]       free_words;
	logic [29:0]         words_left;

	// Byte lane of a 32-bit register selected by the low address bits.
	function automatic logic [31:0] put_byte(input logic [31:0] word,
		input logic [1:0] lane, input logic [7:0] value);
		logic [31:0] res;
		res = word;
		res[lane*8 +: 8] = value;
		return res;
	endfunction

	// Matches a register address against a four-byte register group.
	function automatic logic in_group(input logic [31:0] addr,
		input logic [31:0] base);
		return addr[31:2] == base[31:2];
	endfunction

	assign wr_hit   = reg_wr_i;
	assign start_wr = wr_hit && reg_addr_i == haf_pkg::OFS_START &&
		reg_wdata_i[haf_pkg::BIT_START_READY];
	assign stop_wr  = wr_hit && reg_addr_i == haf_pkg::OFS_STOP &&
		reg_wdata_i[haf_pkg::BIT_STOP_REQ];

	// Configuration registers written by software.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			burst_cfg_q  <= haf_pkg::RST_BURST_CFG;
			threshold_q  <= haf_pkg::RST_THRESHOLD;
			chan_alloc_q <= haf_pkg::RST_CHAN_ALLOC;
			begin_addr_q <= 32'h0000_0000;
			end_addr_q   <= 32'h0000_0000;
		end else if (wr_hit) begin
			if (reg_addr_i == haf_pkg::OFS_BURST_CFG) begin
				burst_cfg_q <= reg_wdata_i;
			end
			if (reg_addr_i == haf_pkg::OFS_THRESHOLD) begin
				threshold_q <= reg_wdata_i;
			end
			if (reg_addr_i == haf_pkg::OFS_CHAN_ALLOC) begin
				chan_alloc_q <= reg_wdata_i;
			end
			if (in_group(reg_addr_i, haf_pkg::OFS_BEGIN_ADDR)) begin
				begin_addr_q <= put_byte(begin_addr_q, reg_addr_i[1:0],
					reg_wdata_i);
			end
			if (in_group(reg_addr_i, haf_pkg::OFS_END_ADDR)) begin
				end_addr_q <= put_byte(end_addr_q, reg_addr_i[1:0],
					reg_wdata_i);
			end
		end
	end

	// Registered read data, valid the cycle after the read strobe.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == haf_pkg::OFS_BURST_CFG) begin
				rdata_q <= burst_cfg_q;
			end else if (reg_addr_i == haf_pkg::OFS_THRESHOLD) begin
				rdata_q <= threshold_q;
			end else if (reg_addr_i == haf_pkg::OFS_CHAN_ALLOC) begin
				rdata_q <= chan_alloc_q;
			end else if (reg_addr_i == haf_pkg::OFS_IRQ_STAT) begin
				rdata_q <= {5'h00, done_q, err_q, 1'b0};
			end else if (reg_addr_i == haf_pkg::OFS_START) begin
				rdata_q <= {7'h00, state_q != haf_pkg::HAF_IDLE};
			end else if (in_group(reg_addr_i, haf_pkg::OFS_BEGIN_ADDR)) begin
				rdata_q <= begin_addr_q[reg_addr_i[1:0]*8 +: 8];
			end else if (in_group(reg_addr_i, haf_pkg::OFS_END_ADDR)) begin
				rdata_q <= end_addr_q[reg_addr_i[1:0]*8 +: 8];
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	// Burst length and code from bits 2:1 of the burst register.
	always_comb begin
		case (haf_pkg::haf_burst_sel_t'(burst_cfg_q[2:1]))
			haf_pkg::HAF_SEL_INCR4: begin
				burst_len  = 5'd4;
				burst_code = haf_pkg::BURST_INCR4;
			end
			haf_pkg::HAF_SEL_INCR8: begin
				burst_len  = 5'd8;
				burst_code = haf_pkg::BURST_INCR8;
			end
			haf_pkg::HAF_SEL_INCR16: begin
				burst_len  = 5'd16;
				burst_code = haf_pkg::BURST_INCR16;
			end
			default: begin
				burst_len  = 5'd1;
				burst_code = haf_pkg::BURST_INCR;
			end
		endcase
	end

	// A fixed burst runs only when the words left and FIFO room allow it.
	assign words_left = end_addr_q[31:2] - addr_q[31:2];
	assign free_words = CW'(DEPTH) - count_q - CW'(dphase_q);
	assign fixed_ok   = {25'h0, burst_len} <= words_left + 30'd1;
	assign can_start  = !stop_req_q && !full_hold_q &&
		chan_alloc_q != 8'h00 &&
		free_words >= CW'(fixed_ok ? burst_len : 5'd1);
	assign last_addr  = addr_q[31:2] == end_addr_q[31:2];

	// Bus address phase driven from the engine state.
	always_comb begin
		ahb_req_o.haddr  = addr_q;
		ahb_req_o.hsize  = haf_pkg::SIZE_WORD;
		ahb_req_o.hwrite = 1'b0;
		ahb_req_o.hburst = haf_pkg::BURST_INCR;
		ahb_req_o.htrans = haf_pkg::TRANS_IDLE;
		if (state_q == haf_pkg::HAF_RUN) begin
			if (beats_left_q != 5'd0) begin
				ahb_req_o.hburst = burst_code;
				ahb_req_o.htrans = haf_pkg::TRANS_SEQ;
			end else if (can_start || nonseq_wait_q) begin
				ahb_req_o.hburst = fixed_ok ? burst_code : haf_pkg::BURST_INCR;
				ahb_req_o.htrans = haf_pkg::TRANS_NONSEQ;
			end
		end
	end

	assign addr_take = ahb_rsp_i.hready && ahb_req_o.htrans[1];
	assign data_take = ahb_rsp_i.hready && dphase_q;
	assign push      = data_take && ahb_rsp_i.hresp == haf_pkg::RESP_OKAY;
	assign pop       = sample_ready_i && count_q != CW'(0);
	assign done_evt  = state_q == haf_pkg::HAF_DRAIN &&
		(!dphase_q || ahb_rsp_i.hready);

	// Engine sequencing: launch, address walk, stop and final data phase.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q      <= haf_pkg::HAF_IDLE;
			addr_q       <= 32'h0000_0000;
			beats_left_q <= 5'd0;
		end else begin
			case (state_q)
				haf_pkg::HAF_IDLE: begin
					if (start_wr) begin
						addr_q       <= {begin_addr_q[31:2], 2'h0};
						beats_left_q <= 5'd0;
						state_q      <= haf_pkg::HAF_RUN;
					end
				end
				haf_pkg::HAF_RUN: begin
					if (addr_take) begin
						addr_q <= addr_q + 32'h0000_0004;
						if (beats_left_q != 5'd0) begin
							beats_left_q <= beats_left_q - 5'd1;
						end else if (fixed_ok) begin
							beats_left_q <= burst_len - 5'd1;
						end
						if (last_addr) begin
							state_q <= haf_pkg::HAF_DRAIN;
						end
					end else if (stop_req_q && beats_left_q == 5'd0 &&
						!nonseq_wait_q) begin
						state_q <= haf_pkg::HAF_DRAIN;
					end
				end
				haf_pkg::HAF_DRAIN: begin
					if (done_evt) begin
						state_q <= haf_pkg::HAF_IDLE;
					end
				end
				default: begin
					state_q <= haf_pkg::HAF_IDLE;
				end
			endcase
		end
	end

	// Data phase pending after an accepted address.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dphase_q <= 1'b0;
		end else if (ahb_rsp_i.hready) begin
			dphase_q <= addr_take;
		end
	end

	// A first beat shown in a wait state must stay until the slave takes it.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nonseq_wait_q <= 1'b0;
		end else begin
			nonseq_wait_q <= ahb_req_o.htrans == haf_pkg::TRANS_NONSEQ &&
				!ahb_rsp_i.hready;
		end
	end

	// Stop request lives until the engine returns to idle.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stop_req_q <= 1'b0;
		end else if (stop_wr && state_q != haf_pkg::HAF_IDLE) begin
			stop_req_q <= 1'b1;
		end else if (state_q == haf_pkg::HAF_IDLE) begin
			stop_req_q <= 1'b0;
		end
	end

	// Sticky status; write one clears, a same-cycle event wins.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
			err_q  <= 1'b0;
		end else begin
			if (done_evt) begin
				done_q <= 1'b1;
			end else if (wr_hit && reg_addr_i == haf_pkg::OFS_IRQ_STAT &&
				reg_wdata_i[haf_pkg::BIT_STAT_DONE]) begin
				done_q <= 1'b0;
			end
			if (data_take && ahb_rsp_i.hresp != haf_pkg::RESP_OKAY) begin
				err_q <= 1'b1;
			end else if (wr_hit && reg_addr_i == haf_pkg::OFS_IRQ_STAT &&
				reg_wdata_i[haf_pkg::BIT_STAT_ERR]) begin
				err_q <= 1'b0;
			end
		end
	end

	// Refill hold: set at full, released at or below the threshold.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			full_hold_q <= 1'b0;
		end else if (count_q == CW'(DEPTH)) begin
			full_hold_q <= 1'b1;
		end else if (32'(count_q) <= 32'(threshold_q)) begin
			full_hold_q <= 1'b0;
		end
	end

	// Sample FIFO storage; error beats are never written.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wptr_q] <= ahb_rsp_i.hrdata;
		end
	end

	// FIFO pointers and fill level.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= (wptr_q == (CW-1)'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= (rptr_q == (CW-1)'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
			end
			count_q <= count_q + CW'(push) - CW'(pop);
		end
	end

	assign sample_valid_o = count_q != CW'(0);
	assign sample_data_o  = mem_q[rptr_q];
	assign chan_enable_o  = chan_alloc_q;
	assign irq_done_o     = done_q;
	assign reg_rdata_o    = rdata_q;

endmodule

// file: tb/haf_audio_fetch_sva.sv
module haf_audio_fetch_sva #(
	parameter int DEPTH = 128
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic [31:0]           reg_addr_i,
	input wire logic                  reg_wr_i,
	input wire logic                  reg_rd_i,
	input wire logic [7:0]            reg_wdata_i,
	input wire logic [7:0]            reg_rdata_o,
	input wire haf_pkg::haf_ahb_req_t ahb_req_o,
	input wire haf_pkg::haf_ahb_rsp_t ahb_rsp_i,
	input wire logic [7:0]            chan_enable_o,
	input wire logic                  irq_done_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// An accepted address phase, and one that opens a single beat.
	sequence s_take;
		ahb_req_o.htrans[1] && ahb_rsp_i.hready;
	endsequence
	sequence s_single;
		s_take ##0 ahb_req_o.hburst == haf_pkg::BURST_INCR
			&& ahb_req_o.htrans == haf_pkg::TRANS_NONSEQ;
	endsequence
	// Stop written while beats are on the bus.
	sequence s_stop_busy;
		reg_wr_i && reg_addr_i == haf_pkg::OFS_STOP && reg_wdata_i[0]
			&& ahb_req_o.htrans != haf_pkg::TRANS_IDLE;
	endsequence
	property p_hold;
		ahb_req_o.htrans[1] && !ahb_rsp_i.hready |=> $stable(ahb_req_o);
	endproperty
	property p_seq_addr;
		s_take ##1 ahb_req_o.htrans == haf_pkg::TRANS_SEQ
			|-> ahb_req_o.haddr == $past(ahb_req_o.haddr) + 32'h4;
	endproperty
	property p_single;
		s_single |=> ahb_req_o.htrans != haf_pkg::TRANS_SEQ;
	endproperty
	property p_burst_keep;
		ahb_req_o.htrans == haf_pkg::TRANS_SEQ |-> $stable(ahb_req_o.hburst);
	endproperty
	property p_stop_done;
		s_stop_busy |-> ##[1:200] irq_done_o;
	endproperty
	property p_done_idle;
		$rose(irq_done_o) |-> ahb_req_o.htrans == haf_pkg::TRANS_IDLE;
	endproperty
	property p_stat;
		reg_rd_i && reg_addr_i == haf_pkg::OFS_IRQ_STAT
			|=> reg_rdata_o[haf_pkg::BIT_STAT_DONE] == $past(irq_done_o);
	endproperty
	property p_unmapped;
		reg_rd_i && reg_addr_i == 32'h0012_3606 |=> reg_rdata_o == 8'h00;
	endproperty
	property p_chan;
		chan_enable_o == 8'h00 && $past(ahb_req_o.htrans) == 2'h0
			|-> ahb_req_o.htrans != haf_pkg::TRANS_NONSEQ;
	endproperty
	a_hold: assert property (p_hold) else $error("request moved in wait");
	a_seq_addr: assert property (p_seq_addr) else $error("bad step");
	a_single: assert property (p_single) else $error("seq after single");
	a_burst_keep: assert property (p_burst_keep) else $error("burst");
	a_stop_done: assert property (p_stop_done) else $error("no done");
	a_done_idle: assert property (p_done_idle) else $error("busy");
	a_stat: assert property (p_stat) else $error("status bit");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	a_chan: assert property (p_chan) else $error("fetch while off");
endmodule

bind haf_audio_fetch haf_audio_fetch_sva #(.DEPTH(DEPTH)) u_haf_audio_fetch_sva (
	.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .ahb_req_o(ahb_req_o),
	.ahb_rsp_i(ahb_rsp_i), .chan_enable_o(chan_enable_o),
	.irq_done_o(irq_done_o));

// file: tb/haf_mem_model.sv
module haf_mem_model (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  slow_i,
	input  wire logic [31:0]           err_addr_i,
	input  wire haf_pkg::haf_ahb_req_t req_i,
	output haf_pkg::haf_ahb_rsp_t      rsp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        dp_q;
	logic        wait_q;
	logic [31:0] addr_q;
	logic [31:0] tog_q;
	logic        err;
	logic        stall;
	// Error beats take the two-cycle response; slow beats wait one cycle.
	assign err = dp_q && addr_q == err_addr_i;
	assign stall = dp_q && (slow_i || err) && !wait_q;
	// Memory word is the inverted address; idle data changes every cycle.
	always_comb begin
		rsp_o.hready = !stall;
		rsp_o.hresp = err ? 2'h1 : haf_pkg::RESP_OKAY;
		rsp_o.hrdata = dp_q ? ~addr_q : tog_q;
	end
	// Data phase follows each accepted address phase.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dp_q <= 1'b0;
			wait_q <= 1'b0;
			addr_q <= 32'h0;
			tog_q <= 32'h5a5a_a5a5;
		end else begin
			tog_q <= ~tog_q;
			wait_q <= stall;
			if (!stall) begin
				dp_q <= req_i.htrans[1];
				addr_q <= req_i.haddr;
			end
		end
	end
endmodule

// file: tb/haf_audio_fetch_test.sv
module haf_audio_fetch_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 32;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic [31:0]           reg_addr_i = 32'h0;
	logic                  reg_wr_i = 1'b0;
	logic                  reg_rd_i = 1'b0;
	logic [7:0]            reg_wdata_i = 8'h00;
	logic [7:0]            reg_rdata_o;
	haf_pkg::haf_ahb_req_t ahb_req_o;
	haf_pkg::haf_ahb_rsp_t ahb_rsp_i;
	logic                  sample_valid_o;
	logic                  sample_ready_i = 1'b0;
	logic [31:0]           sample_data_o;
	logic [7:0]            chan_enable_o;
	logic                  irq_done_o;
	logic                  slow = 1'b0;
	logic [31:0]           err_a = 32'hffff_ffff;
	logic [31:0]           exp_a = 32'h0;
	logic [7:0]            rb;
	logic [2:0]            first_burst = 3'h0;
	logic                  seen_ns = 1'b0;
	int                    failures = 0;
	int                    num_checks = 0;
	int                    popped = 0;
	int                    cyc = 0;
	always #2 clk_i = ~clk_i;
	haf_audio_fetch #(.DEPTH(DEPTH)) u_haf_audio_fetch (.clk_i(clk_i),
		.rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .ahb_req_o(ahb_req_o),
		.ahb_rsp_i(ahb_rsp_i), .sample_valid_o(sample_valid_o),
		.sample_ready_i(sample_ready_i), .sample_data_o(sample_data_o),
		.chan_enable_o(chan_enable_o), .irq_done_o(irq_done_o));
	haf_mem_model u_haf_mem_model (.clk_i(clk_i), .rst_i(rst_i),
		.slow_i(slow), .err_addr_i(err_a), .req_i(ahb_req_o),
		.rsp_o(ahb_rsp_i));
	task automatic final_report();
		if (failures == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Burst code expected for each burst type selection.
	function automatic logic [2:0] sel_code(input logic [1:0] sel);
		case (sel)
			2'h1: return haf_pkg::BURST_INCR4;
			2'h2: return haf_pkg::BURST_INCR8;
			2'h3: return haf_pkg::BURST_INCR16;
			default: return haf_pkg::BURST_INCR;
		endcase
	endfunction
	// Records the first burst, checks popped words, cuts a hang short.
	always @(posedge clk_i) begin
		cyc++;
		if (ahb_req_o.htrans === haf_pkg::TRANS_NONSEQ &&
				ahb_rsp_i.hready === 1'b1 && !seen_ns) begin
			first_burst = ahb_req_o.hburst;
			seen_ns = 1'b1;
		end
		if (sample_valid_o === 1'b1 && sample_ready_i) begin
			if (exp_a == err_a)
				exp_a = exp_a + 32'h4;
			check(sample_data_o, ~exp_a);
			exp_a = exp_a + 32'h4;
			popped++;
		end
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		rb = reg_rdata_o;
	endtask
	task automatic wr4(input logic [31:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(a + 32'(i), v[8*i +: 8]);
	endtask
	task automatic wait_done();
		for (int i = 0; i < 2000 && irq_done_o !== 1'b1; i++)
			@(negedge clk_i);
	endtask
	task automatic t_regs();
		rd(haf_pkg::OFS_BURST_CFG);
		check(rb, haf_pkg::RST_BURST_CFG);
		rd(haf_pkg::OFS_CHAN_ALLOC);
		check(rb, haf_pkg::RST_CHAN_ALLOC);
		check(chan_enable_o, 8'hff);
		wr(32'h0012_3606, 8'h5a);
		rd(32'h0012_3606);
		check(rb, 8'h00);
		wr(haf_pkg::OFS_THRESHOLD, 8'h81);
		rd(haf_pkg::OFS_THRESHOLD);
		check(rb, 8'h81);
	endtask
	task automatic t_run(input logic [1:0] sel, input logic [31:0] base,
			input int n, input logic sl, input logic [31:0] ea, input int k);
		slow = sl;
		err_a = ea;
		exp_a = base;
		popped = 0;
		sample_ready_i = 1'b1;
		wr(haf_pkg::OFS_THRESHOLD, 8'h7e);
		wr(haf_pkg::OFS_BURST_CFG, {5'h0, sel, 1'b0});
		rd(haf_pkg::OFS_BURST_CFG);
		check(rb, {5'h0, sel, 1'b0});
		wr4(haf_pkg::OFS_BEGIN_ADDR, base);
		wr4(haf_pkg::OFS_END_ADDR, base + 32'(4 * (n - 1)));
		seen_ns = 1'b0;
		wr(haf_pkg::OFS_START, 8'h01);
		wait_done();
		check(irq_done_o, 1'b1);
		check(first_burst, sel_code(sel));
		repeat (4) @(negedge clk_i);
		check(popped, k);
		rd(haf_pkg::OFS_IRQ_STAT);
		check(rb[2], 1'b1);
		check(rb[1], k != n);
		wr(haf_pkg::OFS_IRQ_STAT, 8'h06);
		check(irq_done_o, 1'b0);
	endtask
	task automatic t_full();
		sample_ready_i = 1'b0;
		exp_a = 32'h4000;
		wr(haf_pkg::OFS_CHAN_ALLOC, 8'h00);
		wr(haf_pkg::OFS_THRESHOLD, 8'h10);
		wr(haf_pkg::OFS_BURST_CFG, 8'h00);
		wr4(haf_pkg::OFS_BEGIN_ADDR, 32'h4000);
		wr4(haf_pkg::OFS_END_ADDR, 32'h40fc);
		wr(haf_pkg::OFS_START, 8'h01);
		repeat (30) @(negedge clk_i);
		check(sample_valid_o, 1'b0);
		wr(haf_pkg::OFS_CHAN_ALLOC, 8'hff);
		repeat (200) @(negedge clk_i);
		check(ahb_req_o.htrans, haf_pkg::TRANS_IDLE);
		sample_ready_i = 1'b1;
		repeat (DEPTH - 17) @(negedge clk_i);
		sample_ready_i = 1'b0;
		repeat (40) @(negedge clk_i);
		check(ahb_req_o.htrans, haf_pkg::TRANS_IDLE);
		sample_ready_i = 1'b1;
		@(negedge clk_i);
		sample_ready_i = 1'b0;
		for (int i = 0; i < 20 && ahb_req_o.htrans !== 2'h2; i++)
			@(negedge clk_i);
		check(ahb_req_o.htrans, haf_pkg::TRANS_NONSEQ);
		wr(haf_pkg::OFS_STOP, 8'h01);
		wait_done();
		check(irq_done_o, 1'b1);
		repeat (40) begin
			@(negedge clk_i);
			check(ahb_req_o.htrans, haf_pkg::TRANS_IDLE);
		end
		sample_ready_i = 1'b1;
		repeat (DEPTH + 2) @(negedge clk_i);
		check(sample_valid_o, 1'b0);
	endtask
	// Stop while the FIFO is full and the engine waits for room.
	task automatic t_stop_full();
		wr(haf_pkg::OFS_IRQ_STAT, 8'h06);
		sample_ready_i = 1'b0;
		exp_a = 32'h6000;
		wr4(haf_pkg::OFS_BEGIN_ADDR, 32'h6000);
		wr4(haf_pkg::OFS_END_ADDR, 32'h60fc);
		wr(haf_pkg::OFS_START, 8'h01);
		repeat (200) @(negedge clk_i);
		check(ahb_req_o.htrans, haf_pkg::TRANS_IDLE);
		check(irq_done_o, 1'b0);
		wr(haf_pkg::OFS_STOP, 8'h01);
		wait_done();
		check(irq_done_o, 1'b1);
		sample_ready_i = 1'b1;
		repeat (DEPTH + 2) @(negedge clk_i);
		check(sample_valid_o, 1'b0);
		check(ahb_req_o.htrans, haf_pkg::TRANS_IDLE);
	endtask
	// Reset, then each scenario in turn.
	initial begin
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		t_regs();
		for (int s = 0; s < 4; s++)
			t_run(2'(s), 32'h1000 + 32'(s * 256), 20, s[0], '1, 20);
		t_run(2'h0, 32'h2000, 8, 1'b1, 32'h2008, 7);
		t_full();
		t_stop_full();
		final_report();
	end
endmodule
